// File: core/msimg_regs.vh
`ifndef MSIMG_REGS_VH
`define MSIMG_REGS_VH
// ****************************************************************
// Register offsets (byte addresses on APB)
// ****************************************************************
`define MSIMG_OFF_CTRL      12'h000
`define MSIMG_OFF_ADDR_LO   12'h004
`define MSIMG_OFF_ADDR_HI   12'h008
`define MSIMG_OFF_DATA      12'h00c
`define MSIMG_OFF_STATUS    12'h010
`define MSIMG_OFF_MASK      12'h014
`define MSIMG_OFF_SRC       12'h018
// ****************************************************************
// Control word fields
// ****************************************************************
`define MSIMG_CTRL_EN_BIT   0
`define MSIMG_CTRL_REQ_LSB  1
`define MSIMG_CTRL_REQ_MSB  3
`define MSIMG_CTRL_ALLOC_LSB 4
`define MSIMG_CTRL_ALLOC_MSB 6
`define MSIMG_CTRL_A64_BIT  7
`define MSIMG_REQ_TWO       3'h1
`define MSIMG_ALLOC_RST     3'h0
`define MSIMG_ALLOC_ONE     3'h0
`define MSIMG_ALLOC_TWO     3'h1
// ****************************************************************
// PCI encodings
// ****************************************************************
`define MSIMG_CMD_MEMWR     4'h7
`define MSIMG_CMD_DAC       4'hd
`define MSIMG_BE_ALL_N      4'h0
`endif

// File: core/msimg_map.v
`timescale 1ns/1ns
`include "msimg_regs.vh"
// ****************************************************************
// Source to message vector mapping
// ****************************************************************
module msimg_map (
    // Inputs
    input  wire [2:0] alloc,
    input  wire [3:0] pend,
    // Outputs
    output reg  [1:0] vec,
    output reg        any
);
    // Four sources fold onto the messages granted; low source wins
    always @* begin
        any = |pend;
        vec = 2'h0;
        if (pend[0])
            vec = 2'h0;
        else if (pend[1])
            vec = 2'h1;
        else if (pend[2])
            vec = 2'h2;
        else
            vec = 2'h3;
        if (alloc == `MSIMG_ALLOC_ONE) begin
            vec = 2'h0;
        end else if (alloc == `MSIMG_ALLOC_TWO) begin
            vec = {1'b0, vec[0]};
        end
    end
endmodule

// File: core/msimg_top.v
// Local design decisions: the APB interface to the registers and the address map.
`timescale 1ns/1ns
`include "msimg_regs.vh"
module msimg_top (
    // Clock and reset
    input  wire        clk,
    input  wire        rst_n,
    // APB slave
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [11:0] paddr,
    input  wire [31:0] pwdata,
    output reg  [31:0] prdata,
    output reg         pready,
    output reg         pslverr,
    // Interrupt sources, one-cycle pulses
    input  wire [3:0]  src_event,
    // Simplified bus master side of the message write
    output reg         msg_req,
    output reg  [3:0]  msg_cmd,
    output reg  [31:0] msg_addr,
    output reg  [31:0] msg_ad,
    output reg  [3:0]  msg_cbe_n,
    output reg         msg_last,
    input  wire        msg_ack,
    // Legacy interrupt pin and register interrupt
    output reg         legacy_int_n,
    output reg         irq
);
    // ****************************************************************
    // Reset release
    // ****************************************************************
    reg  [1:0]  rst_sync;       // Two-stage release chain
    wire        srst_n;         // Synchronised reset
    // Release chain: reset asserts at once, lifts two edges after rst_n
    // rises, so every register leaves reset on the same clean edge
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n)
            rst_sync <= 2'h0;
        else
            rst_sync <= {rst_sync[0], 1'b1};
    end
    // Internal active-low reset used by every other process
    assign srst_n = rst_sync[1];

    // ****************************************************************
    // Registers
    // ****************************************************************
    // Software visible state; all of it returns to zero on reset
    reg         msi_en;         // Message mode enable
    reg  [2:0]  alloc;          // Granted message count encoding
    reg  [31:0] addr_lo;        // msg_lower_address
    reg  [31:0] addr_hi;        // msg_upper_address
    reg  [15:0] data_val;       // msg_data_value
    reg  [3:0]  status;         // Sticky source flags
    reg  [3:0]  mask;           // Interrupt mask
    reg  [3:0]  pend;           // Events waiting for a message
    wire        wr_acc;         // Write access phase
    wire        rd_acc;         // Read access phase
    wire [1:0]  vec;            // Chosen message vector
    wire        any_pend;       // Any event waiting
    wire [31:0] ctrl_word;      // Control word as read

    // Access phase qualifiers; writes land only on the access edge
    assign wr_acc = psel & penable & pwrite;
    assign rd_acc = psel & penable & ~pwrite;
    // Control word as software sees it: capability bit 7 is fixed high,
    // the request field always asks for two messages, bits above are zero
    assign ctrl_word = {24'h0, 1'b1, alloc, `MSIMG_REQ_TWO, msi_en};

    // Decode of a known offset
    // Unmapped offsets answer with an error and read as zero
    function mapped;
        input [11:0] a;
        begin
            mapped = (a == `MSIMG_OFF_CTRL) || (a == `MSIMG_OFF_ADDR_LO) ||
                     (a == `MSIMG_OFF_ADDR_HI) || (a == `MSIMG_OFF_DATA) ||
                     (a == `MSIMG_OFF_STATUS) || (a == `MSIMG_OFF_MASK) ||
                     (a == `MSIMG_OFF_SRC);
        end
    endfunction

    // Software writable registers
    // Writes to read-only offsets are dropped silently, writes to unmapped ones are dropped with pslverr;
    // the lower address keeps its two low bits clear so that every
    // message lands on a doubleword boundary
    always @(posedge clk or negedge srst_n) begin
        if (!srst_n) begin
            // Software fields start cleared: message mode off, one message granted
            msi_en   <= 1'b0;
            alloc    <= `MSIMG_ALLOC_RST;
            addr_lo  <= 32'h0;
            addr_hi  <= 32'h0;
            data_val <= 16'h0;
            mask     <= 4'h0;
        end else if (wr_acc) begin
            case (paddr)
                `MSIMG_OFF_CTRL: begin
                    // Bits 3:1 and 7 are fixed and ignore writes
                    msi_en <= pwdata[`MSIMG_CTRL_EN_BIT];
                    alloc  <= pwdata[`MSIMG_CTRL_ALLOC_MSB:`MSIMG_CTRL_ALLOC_LSB];
                end
                `MSIMG_OFF_ADDR_LO: addr_lo <= {pwdata[31:2], 2'h0};
                `MSIMG_OFF_ADDR_HI: addr_hi <= pwdata;
                `MSIMG_OFF_DATA:    data_val <= pwdata[15:0];
                `MSIMG_OFF_MASK:    mask <= pwdata[3:0];
                default: begin
                end
            endcase
        end
    end

    // ****************************************************************
    // Interrupt status
    // ****************************************************************
    // Sticky status, read clears, a new event wins over the clear.
    // Only the bits handed out in prdata are cleared: an event that
    // lands on the setup edge is not in the returned word and must
    // survive until the next read.
    always @(posedge clk or negedge srst_n) begin
        if (!srst_n)
            status <= 4'h0;
        else if (rd_acc && paddr == `MSIMG_OFF_STATUS)
            status <= (status & ~prdata[3:0]) | src_event;
        else
            status <= status | src_event;
    end

    // ****************************************************************
    // Register bus answer
    // ****************************************************************
    // APB answer: one cycle of access, registered data
    // The slave answers in the first access cycle, so there are no wait
    // states; data is taken on the setup edge and stands for one cycle
    always @(posedge clk or negedge srst_n) begin
        if (!srst_n) begin
            prdata  <= 32'h0;
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready  <= psel & ~penable;
            pslverr <= psel & ~penable & ~mapped(paddr);
            // Default read data is zero for writes and unmapped reads
            prdata  <= 32'h0;
            if (psel && !penable && !pwrite) begin
                // Read data is chosen on the setup edge from the current state
                case (paddr)
                    `MSIMG_OFF_CTRL:    prdata <= ctrl_word;
                    `MSIMG_OFF_ADDR_LO: prdata <= addr_lo;
                    `MSIMG_OFF_ADDR_HI: prdata <= addr_hi;
                    `MSIMG_OFF_DATA:    prdata <= {16'h0, data_val};
                    `MSIMG_OFF_STATUS:  prdata <= {28'h0, status};
                    `MSIMG_OFF_MASK:    prdata <= {28'h0, mask};
                    `MSIMG_OFF_SRC:     prdata <= {28'h0, pend};
                    default:            prdata <= 32'h0;
                endcase
            end
        end
    end

    // Interrupt level outputs
    // irq follows unmasked status in either mode; the legacy pin is
    // silenced while message mode is on, so the host sees both only while a write under way when message mode is turned off finishes
    always @(posedge clk or negedge srst_n) begin
        if (!srst_n) begin
            irq          <= 1'b0;
            legacy_int_n <= 1'b1;
        end else begin
            irq          <= |(status & mask);
            legacy_int_n <= ~(~msi_en & |(status & mask));
        end
    end

    // ****************************************************************
    // Message write sequencer
    // ****************************************************************
    // One message write is two or three phases: an optional dual address
    // phase carrying the lower half, the address phase with the memory
    // write command, then the data phase. Each phase holds its outputs
    // until msg_ack is seen, so the far side sets the pace.
    localparam ST_IDLE = 2'h0;
    localparam ST_DAC  = 2'h1;
    localparam ST_ADDR = 2'h2;
    localparam ST_DATA = 2'h3;
    // Sequencer bookkeeping
    reg  [1:0]  state;          // Sequencer state
    reg  [1:0]  cur_vec;        // Vector being sent
    reg  [3:0]  done_set;       // Sources covered by this message

    // Picks the vector of the lowest waiting source under the grant
    msimg_map u_map (
        .alloc (alloc),
        .pend  (pend),
        .vec   (vec),
        .any   (any_pend)
    );

    // ****************************************************************
    // Source pending state
    // ****************************************************************
    // Pending events; new arrivals win over completion clear
    // Leaving message mode drops anything still waiting, so no write
    // goes out later for an event that the legacy pin already showed
    always @(posedge clk or negedge srst_n) begin
        if (!srst_n)
            pend <= 4'h0;
        else if (!msi_en)
            pend <= 4'h0;
        // Completion clears the covered sources; fresh pulses still land
        else if (state == ST_DATA && msg_ack)
            pend <= (pend & ~done_set) | src_event;
        else
            pend <= pend | src_event;
    end

    // Phase sequencing with handshake per phase
    // done_set records every source that shares the chosen vector, so
    // one write covers them all; later arrivals of sources outside done_set stay pending
    // and start a write of their own after the one idle cycle
    always @(posedge clk or negedge srst_n) begin
        if (!srst_n) begin
            state     <= ST_IDLE;
            cur_vec   <= 2'h0;
            done_set  <= 4'h0;
            msg_req   <= 1'b0;
            msg_cmd   <= 4'h0;
            msg_addr  <= 32'h0;
            msg_ad    <= 32'h0;
            msg_cbe_n <= 4'hf;
            msg_last  <= 1'b0;
        end else begin
            case (state)
                ST_IDLE: begin
                    msg_req  <= 1'b0;
                    msg_last <= 1'b0;
                    // No new write starts while message mode is off; one already under way finishes
                    if (msi_en && any_pend) begin
                        cur_vec  <= vec;
                        done_set <= (alloc == `MSIMG_ALLOC_ONE) ? pend :
                                    (alloc == `MSIMG_ALLOC_TWO) ?
                                    (vec[0] ? (pend & 4'ha) : (pend & 4'h5)) :
                                    (pend & (4'h1 << vec));
                        msg_req  <= 1'b1;
                        // C/BE carries the command in every address phase
                        if (addr_hi != 32'h0) begin
                            // A nonzero upper half needs the dual address cycle
                            state     <= ST_DAC;
                            msg_cmd   <= `MSIMG_CMD_DAC;
                            msg_addr  <= addr_lo;
                            msg_cbe_n <= `MSIMG_CMD_DAC;
                        end else begin
                            // Zero upper half: one address phase is enough
                            state     <= ST_ADDR;
                            msg_cmd   <= `MSIMG_CMD_MEMWR;
                            msg_addr  <= addr_lo;
                            msg_cbe_n <= `MSIMG_CMD_MEMWR;
                        end
                    end
                end
                ST_DAC: begin
                    // Lower half taken; upper half follows with the real command
                    if (msg_ack) begin
                        state     <= ST_ADDR;
                        msg_cmd   <= `MSIMG_CMD_MEMWR;
                        msg_addr  <= addr_hi;
                        msg_cbe_n <= `MSIMG_CMD_MEMWR;
                    end
                end
                ST_ADDR: begin
                    // Address taken; drive data with the vector in its low bits
                    if (msg_ack) begin
                        state     <= ST_DATA;
                        msg_ad    <= {16'h0, data_val[15:2],
                                      data_val[1:0] | cur_vec};
                        msg_cbe_n <= `MSIMG_BE_ALL_N;
                        msg_last  <= 1'b1;
                    end
                end
                ST_DATA: begin
                    // Data taken; release the bus and return to idle
                    if (msg_ack) begin
                        state     <= ST_IDLE;
                        msg_req   <= 1'b0;
                        msg_last  <= 1'b0;
                        msg_cbe_n <= 4'hf;
                        msg_ad    <= 32'h0;
                    end
                end
                // Unused code falls back to idle
                default: state <= ST_IDLE;
            endcase
        end
    end
endmodule

// File: tb/msimg_props_properties.sv
`timescale 1ns/1ns
// ****************************************************************
// Message and register port checker
// ****************************************************************
module msimg_props (
    // Clock and reset
    input wire        clk,
    input wire        rst_n,
    // APB
    input wire        psel,
    input wire        penable,
    input wire        pwrite,
    input wire [11:0] paddr,
    input wire [31:0] prdata,
    // Message side
    input wire        msg_req,
    input wire [3:0]  msg_cmd,
    input wire [31:0] msg_addr,
    input wire [31:0] msg_ad,
    input wire [3:0]  msg_cbe_n,
    input wire        msg_last,
    input wire        msg_ack,
    // Interrupt outputs
    input wire        legacy_int_n,
    input wire        irq
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    property p_cbe; msg_last |-> msg_cbe_n == 4'h0; endproperty
    a_cbe: assert property (p_cbe) else $error("data phase enables off");
    property p_ad; msg_last |-> msg_ad[31:16] == 16'h0; endproperty
    a_ad: assert property (p_ad) else $error("data phase upper half set");
    property p_hold; msg_req && !msg_ack
        |=> $stable({msg_cmd, msg_addr, msg_cbe_n, msg_last}); endproperty
    a_hold: assert property (p_hold) else $error("phase changed before ack");
    property p_leg; !legacy_int_n |-> irq && !msg_req; endproperty
    a_leg: assert property (p_leg) else $error("legacy pin with message");
    property p_dac; msg_ack && msg_cmd == 4'hd |=> msg_req && msg_cmd == 4'h7 && !msg_last;
    endproperty
    a_dac: assert property (p_dac) else $error("dual cycle order wrong");
    property p_acbe; msg_req && !msg_last |-> msg_cbe_n == msg_cmd; endproperty
    a_acbe: assert property (p_acbe) else $error("address phase command lines wrong");
    property p_data; msg_ack && msg_cmd == 4'h7 && !msg_last |=> msg_last && msg_req; endproperty
    a_data: assert property (p_data) else $error("no data phase");
    property p_end; msg_ack && msg_last |=> !msg_req; endproperty
    a_end: assert property (p_end) else $error("no idle after write");
    property p_cap; psel && !penable && !pwrite && paddr == 12'h000
        |=> prdata[7] && prdata[3:1] == 3'h1; endproperty
    a_cap: assert property (p_cap) else $error("capability bits wrong");
endmodule
bind msimg_top msimg_props i_props (
    .clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .prdata(prdata), .msg_req(msg_req), .msg_cmd(msg_cmd),
    .msg_addr(msg_addr), .msg_ad(msg_ad), .msg_cbe_n(msg_cbe_n), .msg_last(msg_last),
    .msg_ack(msg_ack), .legacy_int_n(legacy_int_n), .irq(irq));

// File: tb/msimg_host.sv
`timescale 1ns/1ns
// ****************************************************************
// Host bridge taking message writes
// ****************************************************************
module msimg_host (
    // Clock and reset
    input  wire        clk,
    input  wire        rst_n,
    // Message side
    input  wire        msg_req,
    input  wire [3:0]  msg_cmd,
    input  wire [31:0] msg_addr,
    input  wire [31:0] msg_ad,
    input  wire        msg_last,
    output reg         msg_ack,
    // Record of the last finished write
    output reg         done,
    output reg         got_dac,
    output reg  [63:0] got_addr,
    output reg  [31:0] got_data
);
    reg [1:0] wait_cnt; // Random wait before an ack
    reg       second;   // Next address phase is the upper half
    // Ack each phase after 0 to 3 cycles and log what was taken
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            msg_ack <= 1'b0;
            done <= 1'b0;
            wait_cnt <= 2'h0;
            second <= 1'b0;
        end else begin
            done <= 1'b0;
            if (msg_ack) begin
                msg_ack <= 1'b0;
                if (msg_last) begin
                    got_data <= msg_ad;
                    done <= 1'b1;
                end else if (msg_cmd == 4'hd) begin
                    got_addr <= {32'h0, msg_addr};
                    got_dac <= 1'b1;
                    second <= 1'b1;
                end else if (second) begin
                    got_addr[63:32] <= msg_addr;
                    second <= 1'b0;
                end else begin
                    got_addr <= {32'h0, msg_addr};
                    got_dac <= 1'b0;
                end
            end else if (msg_req && wait_cnt != 2'h0) begin
                wait_cnt <= wait_cnt - 2'h1;
            end else if (msg_req) begin
                msg_ack <= 1'b1;
                wait_cnt <= $urandom % 4;
            end
        end
    end
endmodule

// File: tb/tb.sv
`timescale 1ns/1ns
module tb;
    // ****************************************************************
    // Signals
    // ****************************************************************
    reg         clk = 1'b0, rst_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    reg  [11:0] paddr = 12'h000;
    reg  [31:0] pwdata = 32'h0, rd, lo, hi, dv;
    reg  [3:0]  src_event = 4'h0;
    reg  [2:0]  al;
    reg         er;
    reg  [15:0] exp_q[$];       // Model: expected message data words in order
    wire [31:0] prdata, msg_addr, msg_ad, got_data;
    wire [63:0] got_addr;
    wire [3:0]  msg_cmd, msg_cbe_n;
    wire        pready, pslverr, msg_req, msg_last, msg_ack, legacy_int_n, irq, done, got_dac;
    integer     n_errors = 0, checked = 0, m, i;
    // Clock of 20 ns
    initial forever #10 clk = ~clk;
    msimg_top i_dut (.clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .src_event(src_event), .msg_req(msg_req), .msg_cmd(msg_cmd),
        .msg_addr(msg_addr), .msg_ad(msg_ad), .msg_cbe_n(msg_cbe_n), .msg_last(msg_last),
        .msg_ack(msg_ack), .legacy_int_n(legacy_int_n), .irq(irq));
    msimg_host i_host (.clk(clk), .rst_n(rst_n), .msg_req(msg_req), .msg_cmd(msg_cmd),
        .msg_addr(msg_addr), .msg_ad(msg_ad), .msg_last(msg_last), .msg_ack(msg_ack),
        .done(done), .got_dac(got_dac), .got_addr(got_addr), .got_data(got_data));
    // ****************************************************************
    // Tasks
    // ****************************************************************
    task stop_test;
        begin
            $display("errors %0d checks %0d", n_errors, checked);
            if (n_errors == 0 && checked > 0)
                $display("Finished cleanly");
            else
                $display("Finished with errors");
            $finish;
        end
    endtask
    // Compare one word
    task chk(input [31:0] got, input [31:0] exp);
        begin
            checked = checked + 1;
            if (got !== exp) begin
                n_errors = n_errors + 1;
                $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
            end
        end
    endtask
    // One APB transfer, waits for pready
    task apb(input [11:0] a, input w, input [31:0] d, output [31:0] r, output e);
        integer k;
        begin
            @(posedge clk);
            psel <= 1'b1;
            pwrite <= w;
            paddr <= a;
            pwdata <= d;
            @(posedge clk);
            penable <= 1'b1;
            k = 0;
            @(posedge clk);
            while (pready !== 1'b1) begin
                k = k + 1;
                if (k > 20) begin
                    n_errors = n_errors + 1;
                    stop_test;
                end
                @(posedge clk);
            end
            r = prdata;
            e = pslverr;
            psel <= 1'b0;
            penable <= 1'b0;
        end
    endtask
    // One-cycle source pulse
    task pulse(input [3:0] v);
        begin
            @(posedge clk);
            src_event <= v;
            @(posedge clk);
            src_event <= 4'h0;
        end
    endtask
    // Wait for the host's record and compare it with the model's next word
    task expect_msg(input [63:0] ea, input ed);
        integer k;
        begin
            k = 0;
            while (done !== 1'b1) begin
                k = k + 1;
                if (k > 60) begin
                    n_errors = n_errors + 1;
                    stop_test;
                end
                @(posedge clk);
            end
            chk(got_addr[31:0], ea[31:0]);
            chk(got_addr[63:32], ea[63:32]);
            chk({31'h0, got_dac}, {31'h0, ed});
            chk(got_data, {16'h0, exp_q.pop_front()});
            @(posedge clk);
        end
    endtask
    // Message number for a source under a grant
    function [15:0] vec(input [2:0] a, input [1:0] s);
        vec = (a == 3'h0) ? 16'h0 : (a == 3'h1) ? {15'h0, s[0]} : {14'h0, s};
    endfunction
    // Model: one write per distinct vector, in order of the lowest source
    task model(input [3:0] v);
        integer j;
        reg [3:0] seen;
        begin
            seen = 4'h0;
            for (j = 0; j < 4; j = j + 1) begin
                if (v[j] && !seen[vec(al, j)]) begin
                    seen[vec(al, j)] = 1'b1;
                    exp_q.push_back(dv[15:0] | vec(al, j));
                end
            end
        end
    endtask
    // ****************************************************************
    // Main sequence
    // ****************************************************************
    initial begin
        void'($urandom(94));
        repeat (5) @(posedge clk);
        rst_n <= 1'b1;
        repeat (3) @(posedge clk);
        apb(12'h000, 1'b0, 32'h0, rd, er);
        chk(rd, 32'h82);
        apb(12'h020, 1'b0, 32'h0, rd, er);
        chk({rd[30:0], er}, 32'h1);
        // Legacy pin, read clear, masking
        apb(12'h014, 1'b1, 32'hf, rd, er);
        pulse(4'h4);
        for (i = 0; i < 10 && legacy_int_n !== 1'b0; i = i + 1) @(posedge clk);
        chk({30'h0, irq, legacy_int_n}, 32'h2);
        apb(12'h010, 1'b0, 32'h0, rd, er);
        chk(rd, 32'h4);
        apb(12'h010, 1'b0, 32'h0, rd, er);
        chk({rd[29:0], irq, legacy_int_n}, 32'h1);
        apb(12'h014, 1'b1, 32'h0, rd, er);
        pulse(4'h1);
        apb(12'h000, 1'b0, 32'h0, rd, er);
        chk({30'h0, irq, legacy_int_n}, 32'h1);
        apb(12'h010, 1'b0, 32'h0, rd, er);
        chk(rd, 32'h1);
        apb(12'h014, 1'b1, 32'hf, rd, er);
        // Message writes for each grant, single and dual cycle
        for (m = 0; m < 6; m = m + 1) begin
            al = m % 3;
            hi = (m < 3) ? 32'h0 : ($urandom | 32'h1);
            lo = $urandom;
            dv = $urandom;
            apb(12'h004, 1'b1, lo, rd, er);
            apb(12'h008, 1'b1, hi, rd, er);
            apb(12'h00c, 1'b1, dv, rd, er);
            apb(12'h000, 1'b1, {25'h0, al, 3'h0, 1'b1}, rd, er);
            apb(12'h000, 1'b0, 32'h0, rd, er);
            chk(rd, {24'h0, 1'b1, al, 3'h1, 1'b1});
            for (i = 0; i < 4; i = i + 1) begin
                pulse(4'h1 << i);
                model(4'h1 << i);
                expect_msg({hi, lo & 32'hfffffffc}, hi != 0);
            end
        end
        // Two sources at once, lowest first
        pulse(4'ha);
        model(4'ha);
        expect_msg({hi, lo & 32'hfffffffc}, 1'b1);
        expect_msg({hi, lo & 32'hfffffffc}, 1'b1);
        // Message mode keeps the legacy pin quiet though irq is up
        chk({30'h0, irq, legacy_int_n}, 32'h3);
        // Two sources sharing one of two messages: one write covers both
        apb(12'h000, 1'b1, 32'h11, rd, er);
        al = 3'h1;
        pulse(4'h5);
        model(4'h5);
        expect_msg({hi, lo & 32'hfffffffc}, 1'b1);
        apb(12'h018, 1'b0, 32'h0, rd, er);
        chk(rd, 32'h0);
        chk(exp_q.size(), 32'h0);
        // Reset in mid-run returns the control word, the upper address and both interrupt outputs to their reset values
        rst_n <= 1'b0;
        repeat (5) @(posedge clk);
        rst_n <= 1'b1;
        repeat (3) @(posedge clk);
        apb(12'h000, 1'b0, 32'h0, rd, er);
        chk(rd, 32'h82);
        chk({30'h0, irq, legacy_int_n}, 32'h1);
        apb(12'h008, 1'b0, 32'h0, rd, er);
        chk(rd, 32'h0);
        stop_test;
    end
endmodule
